// file: dv/board_model.sv
// Board-side model of the GPIO wires and the host width strap
`timescale 1ns/100ps
`default_nettype none
module board_model (
    input wire logic clk,
    input wire logic [15:0] gp_out,
    input wire logic [15:0] gp_oe_n,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic [15:0] gp_in,
    output logic host_data_pin_five
);
    logic [15:0] float_q = 16'h0000;
    // Unpulled pins keep changing so a floating read is never trusted
    always @(posedge clk) float_q <= ~float_q;
    // Strap held low selects the narrow host width
    assign host_data_pin_five = 1'b0;
    // Device wins where it drives; pull-ups on 4-7, pull-downs on 0-3 and 8
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!gp_oe_n[i]) gp_in[i] = gp_out[i];
            else if (ext_en[i]) gp_in[i] = ext_val[i];
            else gp_in[i] = (i > 8) ? float_q[i] : (i > 3 && i < 8);
        end
    end
endmodule
`default_nettype wire

// file: dv/gpio_irq_pin_mux_sva.sv
// Port-level assertions for the pin mux
`timescale 1ns/100ps
`default_nettype none
module gpio_irq_pin_mux_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic pci_select_strap,
    input wire logic nmi_in,
    input wire logic nmi_event,
    input wire logic [3:0] ext_irq_event,
    input wire logic [15:0] gp_in,
    input wire logic [15:0] gp_out,
    input wire logic [15:0] gp_oe_n,
    input wire logic serial_port2_ext_clock,
    input wire logic host_irq_req,
    input wire logic host_irq_out,
    input wire logic host_irq_oe_n,
    input wire logic pci_inta_req,
    input wire logic [4:0] pci_inputs
);
    logic [1:0] up_q;
    // Straps are only trusted a few edges after release
    always @(posedge clk or posedge rst) begin
        if (rst) up_q <= 2'd0;
        else if (up_q != 2'd3) up_q <= up_q + 2'd1;
    end
    wire logic up = (up_q == 2'd3);
    wire logic pci = up && pci_select_strap;
    wire logic [4:0] pins = {gp_in[15:14], gp_in[12], gp_in[9], gp_in[10]};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence nmi_rise;
        !nmi_in ##1 nmi_in;
    endsequence
    sequence any_event;
        nmi_event || ext_irq_event != 4'h0;
    endsequence
    AST_NMI_EDGE: assert property (nmi_rise |-> ##[1:5] nmi_event)
        else $error("nmi rise gave no event");
    AST_NMI_LEVEL: assert property (nmi_in [*8] |-> !nmi_event)
        else $error("nmi level gave an event");
    AST_ONE_EVENT: assert property (any_event |=>
        !(nmi_event && $past(nmi_event)) &&
        (ext_irq_event & $past(ext_irq_event)) == 4'h0)
        else $error("event longer than one cycle");
    AST_RESET_INPUTS: assert property ($past(rst) |->
        gp_oe_n[15:3] == 13'h1fff && gp_oe_n[0]) else $error("pin driven");
    AST_QUARTER: assert property (!gp_oe_n[1] && !$past(gp_oe_n[1], 2)
        |-> gp_out[1] != $past(gp_out[1], 2)) else $error("quarter rate");
    AST_SP2_CLK: assert property (serial_port2_ext_clock |->
        $past(gp_in[8])) else $error("serial clock not from pin 8");
    AST_HOST_IRQ: assert property (up && !pci_select_strap |->
        host_irq_out == $past(host_irq_req) && !host_irq_oe_n)
        else $error("host irq not driven");
    AST_PCI_INTA: assert property (pci && $past(pci_inta_req) |->
        !gp_oe_n[13] && !gp_out[13] && host_irq_oe_n)
        else $error("pci interrupt not driven");
    AST_PCI_IN: assert property (pci |-> pci_inputs == $past(pins))
        else $error("pci inputs wrong");
endmodule
`default_nettype wire

// file: dv/gpio_irq_pin_mux_tb.sv
// Self-checking bench for the pin mux
`timescale 1ns/100ps
`default_nettype none
`include "gpio_mux_regs.vh"
module gpio_irq_pin_mux_tb;
    logic clk = 0, rst = 1, read = 0, write = 0, nmi_in = 0, hd5;
    logic pci_select_strap = 0, host_irq_req = 0, pci_inta_req = 0;
    logic pci_req_req = 0, host_halfword_select = 0, host_dir_select = 0;
    logic [1:0] host_reg_select = 2'h0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata;
    logic [15:0] ext_en = 16'h0, ext_val = 16'h0, gp_in, gp_out, gp_oe_n;
    logic waitrequest, nmi_event, irq, serial_port2_ext_clock;
    logic host_irq_out, host_irq_oe_n, narrow_host_mode;
    logic [3:0] ext_irq_event, host_ctrl_seen;
    logic [4:0] pci_inputs;
    int err_count = 0, checks = 0, cyc = 0;
    gpio_irq_pin_mux DUT (.clk, .rst, .address, .read, .write, .writedata,
        .byteenable(4'hf), .readdata, .waitrequest, .pci_select_strap,
        .serial_port2_strap(1'b0), .host_data_pin_five(hd5), .nmi_in,
        .nmi_event, .ext_irq_event, .irq, .gp_in, .gp_out, .gp_oe_n,
        .serial_port2_ext_clock, .host_irq_req, .host_irq_out,
        .host_irq_oe_n, .pci_inta_req, .pci_req_req, .pci_inputs,
        .host_reg_select, .host_halfword_select, .host_dir_select,
        .host_ctrl_seen, .narrow_host_mode);
    board_model board (.clk, .gp_out, .gp_oe_n, .ext_en, .ext_val, .gp_in,
        .host_data_pin_five(hd5));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic final_report();
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One Avalon cycle, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic t_defaults();
        int n1, n2;
        logic p1, p2;
        @(negedge clk);
        chk(gp_oe_n, 16'hfff9);
        rdc(`REG_GP_DIR, 32'h0);
        rdc(`REG_GP_FUNC, 32'h0);
        rdc(`REG_IRQ_ENABLE, 32'h0);
        rdc(`REG_STRAPS, 32'h4);
        rdc(6'h3c, 32'h0);
        {n1, n2, p1, p2} = {32'd0, 32'd0, gp_out[1], gp_out[2]};
        repeat (12) begin
            @(negedge clk);
            n1 += (gp_out[1] !== p1);
            n2 += (gp_out[2] !== p2);
            {p1, p2} = {gp_out[1], gp_out[2]};
        end
        chk(n1, 6);
        chk(n2, 4);
    endtask
    task automatic t_nmi();
        int n = 0;
        @(posedge clk);
        nmi_in <= 1'b1;
        repeat (10) @(negedge clk) n += (nmi_event === 1'b1);
        chk(n, 1);
        chk(irq, 1'b0);
        rdc(`REG_IRQ_STATUS, 32'h1);
        wr(`REG_IRQ_MASK, 32'h1);
        nmi_in <= 1'b0;
        repeat (2) @(negedge clk);
        chk(irq, 1'b1);
        wr(`REG_IRQ_CLEAR, 32'h1);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        rdc(`REG_IRQ_STATUS, 32'h0);
    endtask
    task automatic t_ext();
        logic [3:0] a = 4'h0, b = 4'h0;
        wr(`REG_GP_DIR, 32'hffff);
        wr(`REG_EDGE_POL, 32'h5);
        wr(`REG_IRQ_ENABLE, 32'hf0);
        ext_en[7:4] <= 4'hf;
        repeat (8) @(negedge clk) a |= ext_irq_event;
        chk(gp_oe_n[7:3], 5'h1e);
        @(posedge clk);
        ext_val[7:4] <= 4'hf;
        repeat (8) @(negedge clk) b |= ext_irq_event;
        chk(b, 4'ha);
        @(posedge clk);
        ext_val[7:4] <= 4'h0;
        repeat (8) @(negedge clk) a |= ext_irq_event;
        chk(a, 4'h5);
        rdc(`REG_IRQ_STATUS, 32'h1e);
        wr(`REG_IRQ_CLEAR, 32'h1f);
    endtask
    task automatic t_func();
        ext_en[8] <= 1'b1;
        ext_val[8] <= 1'b1;
        repeat (3) @(negedge clk);
        chk(serial_port2_ext_clock, 1'b1);
        wr(`REG_GP_DIR, 32'h0);
        wr(`REG_GP_OUT, 32'h1);
        wr(`REG_GP_FUNC, 32'h19);
        repeat (2) @(negedge clk);
        chk(gp_oe_n[2:0], 3'h4);
        chk(gp_out[0], 1'b1);
        chk(serial_port2_ext_clock, 1'b0);
        wr(`REG_GP_FUNC, 32'h2);
        repeat (2) @(negedge clk);
        chk(gp_oe_n[0], 1'b0);
        chk(gp_out[0], 1'b0);
    endtask
    task automatic t_host();
        @(posedge clk);
        host_reg_select <= 2'h2;
        host_halfword_select <= 1'b1;
        host_dir_select <= 1'b1;
        host_irq_req <= 1'b1;
        repeat (2) @(negedge clk);
        chk(host_ctrl_seen, 4'hb);
        chk(host_irq_out, 1'b1);
        chk(narrow_host_mode, 1'b1);
    endtask
    // Second reset with the PCI strap set
    task automatic t_pci();
        @(posedge clk);
        rst <= 1'b1;
        pci_select_strap <= 1'b1;
        pci_inta_req <= 1'b1;
        pci_req_req <= 1'b1;
        ext_en[15:9] <= 7'h7f;
        ext_val[15:9] <= 7'h53;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        chk(pci_inputs, 5'h13);
        chk({gp_oe_n[13], gp_oe_n[11]}, 2'h0);
        chk(host_irq_oe_n, 1'b1);
        chk(host_ctrl_seen, 4'h0);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_defaults();
        t_nmi();
        t_ext();
        t_func();
        t_host();
        t_pci();
        final_report();
    end
endmodule
bind gpio_irq_pin_mux gpio_irq_pin_mux_sva sva (.clk, .rst,
    .pci_select_strap, .nmi_in, .nmi_event, .ext_irq_event, .gp_in, .gp_out,
    .gp_oe_n, .serial_port2_ext_clock, .host_irq_req, .host_irq_out,
    .host_irq_oe_n, .pci_inta_req, .pci_inputs);
`default_nettype wire

// file: hdl/edge_event.v
// Synchroniser and selectable edge detector for one interrupt input
`timescale 1ns/100ps
`default_nettype none
module edge_event (
    input wire clk,
    input wire rst,
    input wire pin,
    input wire falling,
    output reg event_q
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    // Two flops before any edge logic; first flop feeds only the second
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            // One pulse per qualifying edge
            event_q <= falling ? (last_q & ~sync_q) : (~last_q & sync_q);
        end
    end
endmodule
`default_nettype wire

// file: hdl/gpio_irq_pin_mux.v
// GPIO, interrupt and pin-function multiplexing with Avalon-MM registers
// Function
// - NMI raised on rising edge only
// - Pins 4-7 reset as inputs, bidirectional while not enabled as interrupts
// - Enable bits make pins 4-7 interrupt inputs
// - Per-pin edge polarity for pins 4-7
// - Pin 3 input after reset, bidirectional later
// - Pin 0 input default, output option
// - Pin 0 may drive interrupt output
// - Pin 8 serial clock input default, GPIO later
// - Pin 2 sixth-rate clock default, GPIO later
// - Pin 1 quarter-rate clock default, GPIO later
// - PCI strap picks host port or PCI
// - Pins 9-15 GPIO or PCI signals
// - PCI interrupt A and request outputs
// - Host interrupt out, or PCI frame
`timescale 1ns/100ps
`default_nettype none
`include "gpio_mux_regs.vh"
module gpio_irq_pin_mux (
    input wire clk,
    input wire rst,
    // Avalon-MM slave
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    // Straps
    input wire pci_select_strap,
    input wire serial_port2_strap,
    input wire host_data_pin_five,
    // Interrupt inputs and outputs
    input wire nmi_in,
    output reg nmi_event,
    output reg [3:0] ext_irq_event,
    output reg irq,
    // GPIO pins: oe low means the block drives the pin
    input wire [15:0] gp_in,
    output reg [15:0] gp_out,
    output reg [15:0] gp_oe_n,
    // Shared functions
    output reg serial_port2_ext_clock,
    input wire host_irq_req,
    output reg host_irq_out,
    output reg host_irq_oe_n,
    input wire pci_inta_req,
    input wire pci_req_req,
    output reg [4:0] pci_inputs,
    input wire [1:0] host_reg_select,
    input wire host_halfword_select,
    input wire host_dir_select,
    output reg [3:0] host_ctrl_seen,
    output reg narrow_host_mode
);
    reg [15:0] dir_q;
    reg [15:0] out_q;
    reg [5:0] func_q;
    reg [3:0] irq_enable_bits;
    reg [3:0] ext_edge_polarity;
    reg [4:0] status_q;
    reg [4:0] mask_q;
    reg pci_mode_q;
    reg sp2_mode_q;
    reg straps_taken_q;
    reg [1:0] quarter_cnt_q;
    reg [2:0] sixth_cnt_q;
    reg quarter_rate_clock_out;
    reg sixth_rate_clock_out;
    wire nmi_pulse;
    wire [3:0] ext_pulse;
    wire [4:0] events;
    wire [4:0] clr_w;
    wire gp_irq_out;
    wire acc;
    wire [31:0] dir_m;
    wire [31:0] out_m;
    // Half-period counts of the two divided clocks
    localparam [31:0] quarter_last = `DIV_QUARTER / 2 - 1;
    localparam [31:0] sixth_last = `DIV_SIXTH / 2 - 1;
    reg [15:0] oe_n_d;
    reg [15:0] out_d;
    reg [31:0] rd_d;
    integer k;

    // Byte-lane merge on writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // Edge detectors after synchronisers
    edge_event u_nmi (
        .clk(clk),
        .rst(rst),
        .pin(nmi_in),
        .falling(1'b0),
        .event_q(nmi_pulse)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ext
            edge_event u_ext (
                .clk(clk),
                .rst(rst),
                .pin(gp_in[4 + g] & irq_enable_bits[g]),
                .falling(ext_edge_polarity[g]),
                .event_q(ext_pulse[g])
            );
        end
    endgenerate

    // Gating by enable after the detector masks the false edge when enable is cleared
    assign events = {ext_pulse & irq_enable_bits, nmi_pulse};
    assign acc = (read | write) & waitrequest;
    assign dir_m = merge({16'h0000, dir_q}, writedata, byteenable);
    assign out_m = merge({16'h0000, out_q}, writedata, byteenable);
    assign clr_w = (acc & write & (address == `REG_IRQ_CLEAR) & byteenable[0])
        ? writedata[4:0] : 5'h00;
    assign gp_irq_out = func_q[`FUNC_GP_IRQ_LVL];

    // Straps are caught on the first clock after reset release
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pci_mode_q <= 1'b0;
            sp2_mode_q <= 1'b0;
            narrow_host_mode <= 1'b0;
            straps_taken_q <= 1'b0;
        end else if (!straps_taken_q) begin
            straps_taken_q <= 1'b1;
            pci_mode_q <= pci_select_strap;
            sp2_mode_q <= serial_port2_strap;
            narrow_host_mode <= ~host_data_pin_five;
        end
    end

    // Free-running dividers for the fixed-rate clock outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            quarter_cnt_q <= 2'h0;
            sixth_cnt_q <= 3'h0;
            quarter_rate_clock_out <= 1'b0;
            sixth_rate_clock_out <= 1'b0;
        end else begin
            if (quarter_cnt_q == quarter_last[1:0]) begin
                quarter_cnt_q <= 2'h0;
                quarter_rate_clock_out <= ~quarter_rate_clock_out;
            end else begin
                quarter_cnt_q <= quarter_cnt_q + 2'h1;
            end
            if (sixth_cnt_q == sixth_last[2:0]) begin
                sixth_cnt_q <= 3'h0;
                sixth_rate_clock_out <= ~sixth_rate_clock_out;
            end else begin
                sixth_cnt_q <= sixth_cnt_q + 3'h1;
            end
        end
    end

    // Pin multiplexing; all pins except the clock pins 1 and 2 default to input-only
    always @* begin
        oe_n_d = 16'hffff;
        out_d = out_q;
        // Plain bidirectional GPIO where no alternate function applies
        for (k = 3; k < 16; k = k + 1) begin
            if (dir_q[k]) begin
                oe_n_d[k] = 1'b0;
            end
        end
        // Interrupt role forces pins 4-7 to inputs
        for (k = 0; k < 4; k = k + 1) begin
            if (irq_enable_bits[k]) begin
                oe_n_d[4 + k] = 1'b1;
            end
        end
        // Pin 0 is input, output-only GPIO or interrupt output
        if (func_q[`FUNC_GP0_IRQ]) begin
            oe_n_d[0] = 1'b0;
            out_d[0] = gp_irq_out;
        end else if (func_q[`FUNC_GP0_OUT]) begin
            oe_n_d[0] = 1'b0;
        end
        // Pins 1 and 2 carry clocks until released to GPIO
        if (!func_q[`FUNC_GP1_GPIO]) begin
            oe_n_d[1] = 1'b0;
            out_d[1] = quarter_rate_clock_out;
        end else begin
            oe_n_d[1] = ~dir_q[1];
        end
        if (!func_q[`FUNC_GP2_GPIO]) begin
            oe_n_d[2] = 1'b0;
            out_d[2] = sixth_rate_clock_out;
        end else begin
            oe_n_d[2] = ~dir_q[2];
        end
        // Pin 8 is the serial clock input unless reassigned
        if (!func_q[`FUNC_GP8_GPIO]) begin
            oe_n_d[8] = 1'b1;
        end
        // PCI mode takes pins 9-15
        if (pci_mode_q) begin
            oe_n_d[15:9] = 7'h7f;
            oe_n_d[13] = ~pci_inta_req;
            out_d[13] = 1'b0;
            oe_n_d[11] = ~pci_req_req;
            out_d[11] = 1'b0;
        end
    end

    // Registered pin drive and shared-function outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gp_out <= 16'h0000;
            gp_oe_n <= 16'hffff;
            serial_port2_ext_clock <= 1'b0;
            host_irq_out <= 1'b0;
            host_irq_oe_n <= 1'b1;
            pci_inputs <= 5'h00;
            host_ctrl_seen <= 4'h0;
        end else begin
            gp_out <= out_d;
            gp_oe_n <= oe_n_d;
            serial_port2_ext_clock <= func_q[`FUNC_GP8_GPIO] ? 1'b0 : gp_in[8];
            // Host interrupt driven in host mode; frame pin released in PCI
            host_irq_out <= host_irq_req;
            host_irq_oe_n <= pci_mode_q;
            // Reset, clock, grant, IDSEL and C/BE3 inputs in PCI mode
            pci_inputs <= pci_mode_q ?
                {gp_in[15], gp_in[14], gp_in[12], gp_in[9], gp_in[10]}
                : 5'h00;
            // Host control inputs are only sampled in host-port mode
            host_ctrl_seen <= pci_mode_q ? 4'h0 :
                {host_reg_select, host_halfword_select & narrow_host_mode,
                 host_dir_select};
        end
    end

    // Sticky status: a set in the clearing cycle wins
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= 5'h00;
            irq <= 1'b0;
            nmi_event <= 1'b0;
            ext_irq_event <= 4'h0;
        end else begin
            status_q <= (status_q & ~clr_w) | events;
            irq <= |(((status_q & ~clr_w) | events) & mask_q);
            nmi_event <= nmi_pulse;
            ext_irq_event <= ext_pulse & irq_enable_bits;
        end
    end

    // Avalon-MM slave: one wait cycle, answer on the second edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_q <= `RST_GP_DIR;
            out_q <= `RST_GP_OUT;
            func_q <= `RST_GP_FUNC;
            irq_enable_bits <= `RST_IRQ_EN;
            ext_edge_polarity <= `RST_EDGE_POL;
            mask_q <= 5'h00;
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            // Low for one cycle per accepted request, straight from a flop
            waitrequest <= ~acc;
            if (acc & read) begin
                readdata <= rd_d;
            end
            if (acc & write) begin
                case (address)
                    // Pin 0 has no direction bit; its role comes from func
                    `REG_GP_DIR: dir_q <= {dir_m[15:1], 1'b0};
                    `REG_GP_OUT: out_q <= out_m[15:0];
                    `REG_GP_FUNC: if (byteenable[0]) func_q <= writedata[5:0];
                    `REG_IRQ_ENABLE: if (byteenable[0])
                        irq_enable_bits <= writedata[7:4];
                    `REG_EDGE_POL: if (byteenable[0])
                        ext_edge_polarity <= writedata[3:0];
                    `REG_IRQ_MASK: if (byteenable[0]) mask_q <= writedata[4:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    always @* begin
        case (address)
            `REG_GP_DIR: rd_d = {16'h0000, dir_q};
            `REG_GP_OUT: rd_d = {16'h0000, out_q};
            `REG_GP_IN: rd_d = {16'h0000, gp_in};
            `REG_GP_FUNC: rd_d = {26'h0, func_q};
            `REG_IRQ_ENABLE: rd_d = {24'h0, irq_enable_bits, 4'h0};
            `REG_EDGE_POL: rd_d = {28'h0, ext_edge_polarity};
            `REG_IRQ_STATUS: rd_d = {27'h0, status_q};
            `REG_IRQ_MASK: rd_d = {27'h0, mask_q};
            `REG_STRAPS: rd_d = {29'h0, narrow_host_mode, sp2_mode_q,
                pci_mode_q};
            default: rd_d = 32'h00000000;
        endcase
    end
endmodule
`default_nettype wire

// file: shared/gpio_mux_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef GPIO_MUX_REGS_VH
`define GPIO_MUX_REGS_VH

// Byte offsets of the word registers
`define REG_GP_DIR 6'h00
`define REG_GP_OUT 6'h04
`define REG_GP_IN 6'h08
`define REG_GP_FUNC 6'h0c
`define REG_IRQ_ENABLE 6'h10
`define REG_EDGE_POL 6'h14
`define REG_IRQ_STATUS 6'h18
`define REG_IRQ_CLEAR 6'h1c
`define REG_IRQ_MASK 6'h20
`define REG_STRAPS 6'h24

// Function select fields
`define FUNC_GP0_OUT 0
`define FUNC_GP0_IRQ 1
`define FUNC_GP1_GPIO 2
`define FUNC_GP2_GPIO 3
`define FUNC_GP8_GPIO 4
`define FUNC_GP_IRQ_LVL 5

// Status bit positions
`define ST_NMI 0
`define ST_EXT_LO 1

// Reset values
`define RST_GP_DIR 16'h0000
`define RST_GP_OUT 16'h0000
`define RST_GP_FUNC 6'h00
`define RST_IRQ_EN 4'h0
`define RST_EDGE_POL 4'h0

// Clock dividers for the two fixed-rate outputs
`define DIV_QUARTER 4
`define DIV_SIXTH 6

`endif
